// ### scc_map.svh
// offsets, field positions, reset values and key constants for the system config block
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
`define SCC_OFF_CFGW3 16'h0bf0
`define SCC_OFF_CFGW2 16'h0bf4
`define SCC_OFF_CFGW1 16'h0bf8
`define SCC_OFF_CFGW0 16'h0bfc
`define SCC_OFF_CTRL 16'hf200
`define SCC_OFF_IDENT 16'hf220
`define SCC_OFF_KEY 16'hf230
`define SCC_OFF_PINSEL 16'hf300
`define SCC_OFF_MODOFF 16'hf310
`define SCC_BIT_PINLOCK 13
`define SCC_BIT_MODLOCK 12
`define SCC_BIT_SCANEN 3
`define SCC_BIT_TWOWIRE_OUT 0
`define SCC_CTRL_ONES 32'h00000006
`define SCC_CTRL_RESET 32'h0000000b
`define SCC_KEY_RESET 32'h00000000
`define SCC_KEY_FIRST 32'haa996655
`define SCC_KEY_SECOND 32'h556699aa
`define SCC_PWP_HI_MASK 32'h00060000
`endif

// ### scc_pkg.sv
// types shared by the system config block
package scc_pkg;
  // unlock tracker states, gray coded along the key path
  typedef enum logic [1:0] {
    SCC_LOCKED = 2'b00,
    SCC_HALF = 2'b01,
    SCC_OPEN = 2'b11
  } scc_unlock_t;
endpackage

// ### scc_unlock.sv
// unlock key sequence tracker for the system config block
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_unlock (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic keyWrite,
  input wire logic [31:0] keyData,
  output logic unlocked
);
  // -----------------------------------------------
  // key sequence state
  // -----------------------------------------------
  scc_pkg::scc_unlock_t state_reg; // current tracker state
  scc_pkg::scc_unlock_t state_next; // next tracker state

  // RULE_10 key sequence matching
  always_comb begin
    state_next = state_reg;
    if (keyWrite) begin
      case (state_reg)
        scc_pkg::SCC_LOCKED: begin
          state_next = (keyData == `SCC_KEY_FIRST) ? scc_pkg::SCC_HALF : scc_pkg::SCC_LOCKED;
        end
        scc_pkg::SCC_HALF: begin
          state_next = (keyData == `SCC_KEY_SECOND) ? scc_pkg::SCC_OPEN : scc_pkg::SCC_LOCKED;
        end
        default: begin
          // any further key write relocks
          state_next = (keyData == `SCC_KEY_FIRST) ? scc_pkg::SCC_HALF : scc_pkg::SCC_LOCKED;
        end
      endcase
    end
  end

  // state register, frozen while clock enable low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= scc_pkg::SCC_LOCKED;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign unlocked = (state_reg == scc_pkg::SCC_OPEN);
endmodule

// ### scc_system_config.sv
// system configuration register bank on an ahb-lite slave port
`timescale 1ns/1ps
`include "scc_map.svh"

// What this block does
// RULE_01: pin-select lock blocks pin-select writes
// RULE_02: module-disable lock blocks module-off writes
// RULE_03: scan port enable bit, resets one
// RULE_04: two-wire test-out enable bit, resets one
// RULE_05: bits two and one read one
// RULE_06: other unimplemented bits read zero
// RULE_07: lock bits change only when unlocked
// RULE_08: identity word: revision over device id
// RULE_09: config words read programmed contents; word zero masks SCC_PWP_HI_MASK bits unless big flash
// RULE_10: key sequence grants unlock, mismatch relocks
// RULE_11: identity and config words ignore writes
module scc_system_config (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [3:0] revisionIn,
  input wire logic [27:0] deviceIdIn,
  input wire logic [31:0] cfgWord0In,
  input wire logic [31:0] cfgWord1In,
  input wire logic [31:0] cfgWord2In,
  input wire logic [31:0] cfgWord3In,
  input wire logic bigFlash,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic scanPortEnable,
  output logic twoWireTestOutEnable,
  output logic pinSelectLock,
  output logic moduleDisableLock,
  output logic [31:0] pinSelectRegs,
  output logic [31:0] moduleOffRegs,
  output logic unlockedOut
);
  // -----------------------------------------------
  // pin synchronisers for variant and programmed words
  // -----------------------------------------------
  logic [31:0] idMeta_reg; // first stage, identity
  logic [31:0] idSync_reg; // second stage, identity
  logic [127:0] cfgMeta_reg; // first stage, config words
  logic [127:0] cfgSync_reg; // second stage, config words
  logic flashMeta_reg; // first stage, flash size strap
  logic flashSync_reg; // second stage, flash size strap

  // two flops before any logic sees outside levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idMeta_reg <= 32'h00000000;
      idSync_reg <= 32'h00000000;
      cfgMeta_reg <= {128{1'b0}};
      cfgSync_reg <= {128{1'b0}};
      flashMeta_reg <= 1'b0;
      flashSync_reg <= 1'b0;
    end else if (clkEn) begin
      idMeta_reg <= {revisionIn, deviceIdIn};
      idSync_reg <= idMeta_reg;
      cfgMeta_reg <= {cfgWord3In, cfgWord2In, cfgWord1In, cfgWord0In};
      cfgSync_reg <= cfgMeta_reg;
      flashMeta_reg <= bigFlash;
      flashSync_reg <= flashMeta_reg;
    end
  end

  // -----------------------------------------------
  // ahb address phase capture
  // -----------------------------------------------
  logic addrValid; // a transfer is being offered
  logic wrPend_reg; // data phase of a write
  logic rdPend_reg; // data phase of a read
  logic [15:0] addr_reg; // latched low address

  assign addrValid = hsel && htrans[1] && hready;

  // capture the transfer for its data phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      addr_reg <= 16'h0000;
    end else if (clkEn) begin
      if (hready) begin
        wrPend_reg <= addrValid && hwrite;
        rdPend_reg <= addrValid && !hwrite;
        addr_reg <= haddr[15:0];
      end
    end
  end

  // -----------------------------------------------
  // address decode
  // -----------------------------------------------
  logic hitCtrl; // control register
  logic hitKey; // key register
  logic hitIdent; // identity word
  logic hitPin; // pin-select registers
  logic hitMod; // module-off registers
  logic hitCfg0; // config word zero
  logic hitCfg1; // config word one
  logic hitCfg2; // config word two
  logic hitCfg3; // config word three

  assign hitCtrl = (addr_reg == `SCC_OFF_CTRL);
  assign hitKey = (addr_reg == `SCC_OFF_KEY);
  assign hitIdent = (addr_reg == `SCC_OFF_IDENT);
  assign hitPin = (addr_reg == `SCC_OFF_PINSEL);
  assign hitMod = (addr_reg == `SCC_OFF_MODOFF);
  assign hitCfg0 = (addr_reg == `SCC_OFF_CFGW0);
  assign hitCfg1 = (addr_reg == `SCC_OFF_CFGW1);
  assign hitCfg2 = (addr_reg == `SCC_OFF_CFGW2);
  assign hitCfg3 = (addr_reg == `SCC_OFF_CFGW3);

  // -----------------------------------------------
  // unlock tracker
  // -----------------------------------------------
  logic keyWrite; // key register written this cycle
  logic unlocked; // unlock sequence complete
  logic [31:0] key_reg; // last written key value

  assign keyWrite = wrPend_reg && hitKey;

  // RULE_10 key writes drive the tracker
  scc_unlock u_unlock (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .keyWrite(keyWrite),
    .keyData(hwdata),
    .unlocked(unlocked)
  );

  // -----------------------------------------------
  // control register fields
  // -----------------------------------------------
  logic pinLock_reg; // pin-select lock
  logic modLock_reg; // module-disable lock
  logic scanEn_reg; // scan port enable
  logic two_wire_test_out_enable_reg; // two-wire test output enable
  logic ctrlWrite; // control register write strobe
  logic [31:0] ctrlRead; // assembled control word

  assign ctrlWrite = wrPend_reg && hitCtrl;

  // control bits update
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinLock_reg <= 1'b0;
      modLock_reg <= 1'b0;
      scanEn_reg <= 1'b1;
      two_wire_test_out_enable_reg <= 1'b1;
    end else if (clkEn && ctrlWrite) begin
      // RULE_07 locks change only once unlocked
      if (unlocked) begin
        pinLock_reg <= hwdata[`SCC_BIT_PINLOCK];
        modLock_reg <= hwdata[`SCC_BIT_MODLOCK];
      end
      // RULE_03 scan port enable written
      scanEn_reg <= hwdata[`SCC_BIT_SCANEN];
      // RULE_04 test out enable written
      two_wire_test_out_enable_reg <= hwdata[`SCC_BIT_TWOWIRE_OUT];
    end
  end

  // RULE_05 fixed ones, RULE_06 zeros elsewhere
  assign ctrlRead = `SCC_CTRL_ONES
    | ({31'h00000000, pinLock_reg} << `SCC_BIT_PINLOCK)
    | ({31'h00000000, modLock_reg} << `SCC_BIT_MODLOCK)
    | ({31'h00000000, scanEn_reg} << `SCC_BIT_SCANEN)
    | ({31'h00000000, two_wire_test_out_enable_reg} << `SCC_BIT_TWOWIRE_OUT);

  // -----------------------------------------------
  // key and guarded peripheral registers
  // -----------------------------------------------
  logic [31:0] pinSel_reg; // pin-select contents
  logic [31:0] modOff_reg; // module-off contents

  // key holding and guarded writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      key_reg <= `SCC_KEY_RESET;
      pinSel_reg <= 32'h00000000;
      modOff_reg <= 32'h00000000;
    end else if (clkEn) begin
      if (keyWrite) begin
        key_reg <= hwdata;
      end
      // RULE_01 pin-select writes only while pin-select lock clear
      if (wrPend_reg && hitPin && !pinLock_reg) begin
        pinSel_reg <= hwdata;
      end
      // RULE_02 module-off writes only while module-disable lock clear
      if (wrPend_reg && hitMod && !modLock_reg) begin
        modOff_reg <= hwdata;
      end
    end
  end

  // -----------------------------------------------
  // read mux
  // -----------------------------------------------
  logic [31:0] cfg0View; // config word zero as read
  logic [31:0] readMux; // selected read word

  // RULE_09 upper write-protect bits only on big flash
  assign cfg0View = flashSync_reg ? cfgSync_reg[31:0] : (cfgSync_reg[31:0] & ~`SCC_PWP_HI_MASK);

  // RULE_08 identity word, RULE_11 read-only words
  always_comb begin
    if (hitCtrl) begin
      readMux = ctrlRead;
    end else if (hitIdent) begin
      readMux = idSync_reg;
    end else if (hitKey) begin
      readMux = key_reg;
    end else if (hitPin) begin
      readMux = pinSel_reg;
    end else if (hitMod) begin
      readMux = modOff_reg;
    end else if (hitCfg0) begin
      readMux = cfg0View;
    end else if (hitCfg1) begin
      readMux = cfgSync_reg[63:32];
    end else if (hitCfg2) begin
      readMux = cfgSync_reg[95:64];
    end else if (hitCfg3) begin
      readMux = cfgSync_reg[127:96];
    end else begin
      // unmapped reads as zero
      readMux = 32'h00000000;
    end
  end

  // -----------------------------------------------
  // registered outputs
  // -----------------------------------------------
  // read data, bus status and control levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      scanPortEnable <= 1'b1;
      twoWireTestOutEnable <= 1'b1;
      pinSelectLock <= 1'b0;
      moduleDisableLock <= 1'b0;
      pinSelectRegs <= 32'h00000000;
      moduleOffRegs <= 32'h00000000;
      unlockedOut <= 1'b0;
    end else if (clkEn) begin
      // read word loaded during the wait state, stands while ready is high again
      hrdata <= (rdPend_reg && !hreadyout) ? readMux : 32'h00000000;
      // one wait state per read so the registered data is valid in its data phase
      hreadyout <= !(addrValid && !hwrite);
      hresp <= 1'b0;
      scanPortEnable <= scanEn_reg;
      twoWireTestOutEnable <= two_wire_test_out_enable_reg;
      pinSelectLock <= pinLock_reg;
      moduleDisableLock <= modLock_reg;
      pinSelectRegs <= pinSel_reg;
      moduleOffRegs <= modOff_reg;
      unlockedOut <= unlocked;
    end
  end
endmodule

// ### scc_system_config_chk.sv
// port assertions for the system config register bank
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_system_config_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic scanPortEnable,
  input wire logic twoWireTestOutEnable,
  input wire logic pinSelectLock,
  input wire logic moduleDisableLock,
  input wire logic [31:0] pinSelectRegs,
  input wire logic [31:0] moduleOffRegs,
  input wire logic unlockedOut
);
  // one clock domain, reset gates every check
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  bus_okay_a: assert property (!hresp) else $error("bus answer not okay");
  read_wait_a: assert property (!hreadyout && clkEn |=> hreadyout) else $error("wait state longer than one cycle");
  reset_values_a: assert property ($fell(rst) |-> scanPortEnable && twoWireTestOutEnable
    && !pinSelectLock && !moduleDisableLock) else $error("wrong values after reset");
  pin_lock_gate_a: assert property ($changed(pinSelectLock) |->
    $past(unlockedOut) || $past(unlockedOut, 2) || $past(unlockedOut, 3)) else $error("pin lock moved locked");
  mod_lock_gate_a: assert property ($changed(moduleDisableLock) |->
    $past(unlockedOut) || $past(unlockedOut, 2) || $past(unlockedOut, 3)) else $error("module lock moved locked");
  pin_write_gate_a: assert property ($changed(pinSelectRegs) |->
    !$past(pinSelectLock) || !$past(pinSelectLock, 2)) else $error("pin select written while locked");
  mod_write_gate_a: assert property ($changed(moduleOffRegs) |->
    !$past(moduleDisableLock) || !$past(moduleDisableLock, 2)) else $error("module off written while locked");
  unlock_key_a: assert property ($rose(unlockedOut) |-> $past(hwdata) == `SCC_KEY_SECOND
    || $past(hwdata, 2) == `SCC_KEY_SECOND || $past(hwdata, 3) == `SCC_KEY_SECOND) else $error("unlock without key");
  freeze_hold_a: assert property (!clkEn [*3] |-> $stable(pinSelectRegs) && $stable(scanPortEnable)
    && $stable(unlockedOut)) else $error("state moved while frozen");
endmodule
bind scc_system_config scc_system_config_chk chk (.sys_clk, .rst, .clkEn, .hwdata, .hreadyout, .hresp,
  .scanPortEnable, .twoWireTestOutEnable, .pinSelectLock, .moduleDisableLock, .pinSelectRegs,
  .moduleOffRegs, .unlockedOut);

// ### tb_scc_system_config.sv
// self-checking testbench for the system config register bank
`timescale 1ns/1ps
`include "scc_map.svh"
module tb_scc_system_config;
  // ----------------------------------------
  // signals and addresses
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [3:0] revisionIn = 4'h5; // arbitrary variant code
  logic [27:0] deviceIdIn = 28'h0a1b2c3; // arbitrary variant code
  logic [31:0] cfgWord0In = 32'h0007_8123;
  logic [31:0] cfgWord1In = 32'h0055_aa01;
  logic [31:0] cfgWord2In = 32'h0007_0a77;
  logic [31:0] cfgWord3In = 32'hf000_1234;
  logic bigFlash = 1'b0;
  logic [31:0] hrdata, pinSelectRegs, moduleOffRegs;
  logic hreadyout, hresp, scanPortEnable, twoWireTestOutEnable, pinSelectLock, moduleDisableLock, unlockedOut;
  int failures = 0;
  int n_compared = 0;
  localparam logic [31:0] A_CTRL = {16'h0, `SCC_OFF_CTRL};
  localparam logic [31:0] A_KEY = {16'h0, `SCC_OFF_KEY};
  localparam logic [31:0] A_ID = {16'h0, `SCC_OFF_IDENT};
  localparam logic [31:0] A_PIN = {16'h0, `SCC_OFF_PINSEL};
  localparam logic [31:0] A_MOD = {16'h0, `SCC_OFF_MODOFF};
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  scc_system_config uut (.*);
  always #12.5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one ahb single word transfer, waits on ready in both phases
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr; hsize <= 3'h2;
    do begin @(negedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 40);
    @(posedge sys_clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(negedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    @(posedge sys_clk);
    if (n >= 40) begin
      failures++;
      $display("ERROR bus wait expected ready seen none");
      close_out;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(what, exp, r);
  endtask
  // mirrored outputs trail the registers
  task automatic settle;
    repeat (3) @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_state;
    rd(A_CTRL, 32'h0000_000f, "control reset");
    rd(A_KEY, 32'h0, "key reset");
    rd(32'h0000_0100, 32'h0, "unmapped read");
    chk("scan out", 32'h1, {31'h0, scanPortEnable});
    chk("tdo out", 32'h1, {31'h0, twoWireTestOutEnable});
  endtask
  task automatic t_ctrl_bits;
    wr(A_CTRL, 32'hffff_ffff);
    rd(A_CTRL, 32'h0000_000f, "control all ones");
    wr(A_CTRL, 32'h0);
    settle;
    rd(A_CTRL, 32'h0000_0006, "control zeros");
    chk("scan off", 32'h0, {31'h0, scanPortEnable});
    chk("tdo off", 32'h0, {31'h0, twoWireTestOutEnable});
    wr(A_CTRL, 32'h0000_000b);
  endtask
  task automatic t_locks;
    wr(A_PIN, 32'h1234_5678);
    wr(A_MOD, 32'h00ab_cdef);
    settle;
    chk("pin regs open", 32'h1234_5678, pinSelectRegs);
    chk("module regs open", 32'h00ab_cdef, moduleOffRegs);
    wr(A_KEY, `SCC_KEY_FIRST);
    wr(A_KEY, `SCC_KEY_SECOND);
    settle;
    chk("unlocked", 32'h1, {31'h0, unlockedOut});
    wr(A_CTRL, 32'h0000_300b);
    wr(A_KEY, 32'h0000_0001);
    settle;
    chk("relocked", 32'h0, {31'h0, unlockedOut});
    rd(A_CTRL, 32'h0000_300f, "locks set");
    chk("pin lock out", 32'h1, {31'h0, pinSelectLock});
    chk("module lock out", 32'h1, {31'h0, moduleDisableLock});
    wr(A_PIN, 32'h0);
    wr(A_MOD, 32'h0);
    wr(A_CTRL, 32'h0000_000b);
    settle;
    chk("pin regs held", 32'h1234_5678, pinSelectRegs);
    chk("module regs held", 32'h00ab_cdef, moduleOffRegs);
    rd(A_CTRL, 32'h0000_300f, "locks held");
  endtask
  task automatic t_ident;
    rd(A_ID, {revisionIn, deviceIdIn}, "identity");
    wr(A_ID, 32'h0);
    rd(A_ID, {revisionIn, deviceIdIn}, "identity kept");
    rd({16'h0, `SCC_OFF_CFGW0}, cfgWord0In & ~`SCC_PWP_HI_MASK, "word zero small");
    bigFlash <= 1'b1;
    settle;
    rd({16'h0, `SCC_OFF_CFGW0}, cfgWord0In, "word zero big");
    rd({16'h0, `SCC_OFF_CFGW1}, cfgWord1In, "word one");
    rd({16'h0, `SCC_OFF_CFGW2}, cfgWord2In, "word two");
    wr({16'h0, `SCC_OFF_CFGW3}, 32'h0);
    rd({16'h0, `SCC_OFF_CFGW3}, cfgWord3In, "word three kept");
    clkEn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    clkEn <= 1'b1;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    settle;
    t_reset_state;
    t_ctrl_bits;
    t_locks;
    t_ident;
    close_out;
  end
endmodule
